/* File: rtl/bioprt_consts.vh */
// constants for the bidirectional i/o port block
`ifndef BIOPRT_CONSTS_VH
`define BIOPRT_CONSTS_VH

`define BIOPRT_ADDR_W          7
`define BIOPRT_FIRST_PORT_ADDR 7'h05
`define BIOPRT_SECOND_PORT_ADDR 7'h06
`define BIOPRT_THIRD_PORT_ADDR 7'h07
`define BIOPRT_FIRST_PORT_W    4
`define BIOPRT_DIR_RESET       8'hFF
`define BIOPRT_ZERO_BYTE       8'h00
`define BIOPRT_SEL_FIRST       2'h1
`define BIOPRT_SEL_SECOND      2'h2
`define BIOPRT_SEL_THIRD       2'h3

`endif

/* File: rtl/bioprt_ports.v */
// three general-purpose i/o ports with write-only direction registers
// What this block does
// R1 - a port read returns the live pin levels, never the output latches.
// R2 - any reset loads every direction register with all ones so every pin is an input.
// R3 - the first port at 05h has only four pins and bits 7 to 4 read as zero.
// R4 - the second port at 06h is a full eight-bit bidirectional port.
// R5 - address 07h is a third eight-bit port on some variants and plain storage on the rest.
// R6 - direction registers load only through the direction command and cannot be read.
// R7 - a direction bit of one floats the pin and zero drives the pin from its latch.
// R8 - output latches hold until software writes the port again.
// R9 - inputs are not latched, so outside circuitry holds a level until it is read.
// R10 - each pin has its own direction bit, so inputs and outputs mix in a port.
// R11 - bit set and clear read all pins, change one bit and write every latch.
// R12 - writes land at the end of the cycle and reads sample pins at its start.
// R13 - software should put an unrelated instruction between a write and a read of one port.
// R14 - data latches are not cleared by any reset and keep their contents.
// R15 - a direction write reaches the drivers at the end of the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "bioprt_consts.vh"

module bioprt_ports #(
    parameter HAS_THIRD_PORT = 1
) (
    // clock, reset, enable
    input  wire                       ref_clk_i,
    input  wire                       nrst_i,
    input  wire                       cyc_en_i,
    // core register side
    input  wire [`BIOPRT_ADDR_W-1:0]  file_addr_i,
    input  wire                       file_wr_i,
    input  wire [7:0]                 file_wdata_i,
    input  wire                       bit_op_i,
    input  wire                       bit_val_i,
    input  wire [2:0]                 bit_idx_i,
    input  wire                       dir_wr_i,
    input  wire [1:0]                 dir_sel_i,
    input  wire [7:0]                 work_reg_i,
    output wire [7:0]                 file_rdata_o,
    output wire                       file_hit_o,
    // first port pins
    input  wire [3:0]                 first_port_pin_i,
    output wire [3:0]                 first_port_pin_o,
    output wire [3:0]                 first_port_pin_oe_o,
    // second port pins
    input  wire [7:0]                 second_port_pin_i,
    output wire [7:0]                 second_port_pin_o,
    output wire [7:0]                 second_port_pin_oe_o,
    // third port pins
    input  wire [7:0]                 third_port_pin_i,
    output wire [7:0]                 third_port_pin_o,
    output wire [7:0]                 third_port_pin_oe_o
);

    reg  [3:0] first_latch_reg;
    reg  [7:0] second_latch_reg;
    reg  [7:0] third_latch_reg;
    reg  [3:0] first_port_direction_reg;
    reg  [7:0] second_port_direction_reg;
    reg  [7:0] third_port_direction_reg;
    reg  [7:0] rd_data;
    reg        rd_hit;
    reg  [7:0] wr_value;

    wire sel_first  = (file_addr_i == `BIOPRT_FIRST_PORT_ADDR);
    wire sel_second = (file_addr_i == `BIOPRT_SECOND_PORT_ADDR);
    wire sel_third  = (file_addr_i == `BIOPRT_THIRD_PORT_ADDR);
    wire wr_any     = cyc_en_i & (file_wr_i | bit_op_i);

    // pins read live and nothing holds them, so a level must stand until this read
    // R9
    // without a third port the address reads its storage
    always @* begin
        rd_data = `BIOPRT_ZERO_BYTE;
        rd_hit  = 1'b1;
        if (sel_first) begin
            rd_data = {{(8-`BIOPRT_FIRST_PORT_W){1'b0}}, first_port_pin_i}; // R1 R3
        end else if (sel_second) begin
            rd_data = second_port_pin_i; // R1 R4
        end else if (sel_third) begin
            rd_data = (HAS_THIRD_PORT != 0) ? third_port_pin_i : third_latch_reg; // R5
        end else begin
            rd_hit = 1'b0;
        end
    end

    assign file_rdata_o = rd_data;
    assign file_hit_o   = rd_hit;

    // bit ops modify the sampled pin image, so input-pin latches pick up pin levels
    always @* begin
        wr_value = file_wdata_i;
        if (bit_op_i) begin
            wr_value            = rd_data; // R11
            wr_value[bit_idx_i] = bit_val_i; // R11
        end
    end

    // data latches have no reset: they survive every reset
    always @(posedge ref_clk_i) begin
        if (wr_any) begin // R12
            if (sel_first) begin
                first_latch_reg <= wr_value[`BIOPRT_FIRST_PORT_W-1:0]; // R14 R8
            end else if (sel_second) begin
                second_latch_reg <= wr_value; // R14 R8
            end else if (sel_third) begin
                third_latch_reg <= wr_value; // R5 R8
            end
        end
    end

    // direction registers, written only by the direction command
    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            first_port_direction_reg  <= {`BIOPRT_FIRST_PORT_W{1'b1}}; // R2
            second_port_direction_reg <= `BIOPRT_DIR_RESET; // R2
            third_port_direction_reg  <= `BIOPRT_DIR_RESET; // R2
        end else if (cyc_en_i && dir_wr_i) begin // R6 R15
            case (dir_sel_i)
                `BIOPRT_SEL_FIRST: begin
                    first_port_direction_reg <= work_reg_i[`BIOPRT_FIRST_PORT_W-1:0];
                end
                `BIOPRT_SEL_SECOND: begin
                    second_port_direction_reg <= work_reg_i;
                end
                `BIOPRT_SEL_THIRD: begin
                    third_port_direction_reg <= work_reg_i;
                end
                default: begin
                end
            endcase
        end
    end

    // per-pin drivers: enable is the inverse of each direction bit
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            if (g < `BIOPRT_FIRST_PORT_W) begin : g_first
                assign first_port_pin_oe_o[g] = ~first_port_direction_reg[g]; // R7 R10
                assign first_port_pin_o[g]    = first_latch_reg[g] & ~first_port_direction_reg[g];
            end
            assign second_port_pin_oe_o[g] = ~second_port_direction_reg[g]; // R7 R10
            assign second_port_pin_o[g]    = second_latch_reg[g] & ~second_port_direction_reg[g];
            assign third_port_pin_oe_o[g]  = (HAS_THIRD_PORT != 0) & ~third_port_direction_reg[g];
            assign third_port_pin_o[g]     = third_latch_reg[g] & third_port_pin_oe_o[g]; // R5 R7
        end
    endgenerate

endmodule

`default_nettype wire

/* File: bench/bioprt_checker.sv */
// concurrent checks on the port block's register and pin side
`timescale 1ns/100ps
`default_nettype none
module bioprt_checker (
    input wire logic ref_clk_i, nrst_i, cyc_en_i, file_wr_i, bit_op_i, bit_val_i, dir_wr_i,
    input wire logic [6:0] file_addr_i,
    input wire logic [2:0] bit_idx_i,
    input wire logic [1:0] dir_sel_i,
    input wire logic [3:0] first_port_pin_i,
    input wire logic [7:0] file_wdata_i, work_reg_i, file_rdata_o, third_port_pin_i,
    input wire logic [7:0] second_port_pin_i, second_port_pin_o, second_port_pin_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_wr2; cyc_en_i && file_wr_i && !bit_op_i && file_addr_i == 7'h06; endsequence
    sequence s_bit2; cyc_en_i && bit_op_i && file_addr_i == 7'h06; endsequence
    property p_rst; disable iff (1'b0) !nrst_i |=> second_port_pin_oe_o == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset left a driver on");
    property p_rd1; file_addr_i == 7'h05 |-> file_rdata_o == {4'h0, first_port_pin_i}; endproperty
    a_rd1: assert property (p_rd1) else $error("first port read wrong");
    property p_rd2; file_addr_i == 7'h06 |-> file_rdata_o == second_port_pin_i; endproperty
    a_rd2: assert property (p_rd2) else $error("second port read wrong");
    property p_rd3; file_addr_i == 7'h07 |-> file_rdata_o == third_port_pin_i; endproperty
    a_rd3: assert property (p_rd3) else $error("third port read wrong");
    property p_wr; s_wr2 |=> second_port_pin_o == ($past(file_wdata_i) & second_port_pin_oe_o);
    endproperty
    a_wr: assert property (p_wr) else $error("write not on pins");
    property p_bit; s_bit2 |=> !second_port_pin_oe_o[$past(bit_idx_i)]
        || second_port_pin_o[$past(bit_idx_i)] == $past(bit_val_i); endproperty
    a_bit: assert property (p_bit) else $error("bit op wrong");
    property p_dir; cyc_en_i && dir_wr_i && dir_sel_i == 2'h2
        |=> second_port_pin_oe_o == ~$past(work_reg_i); endproperty
    a_dir: assert property (p_dir) else $error("direction wrong");
    // masked compare so a direction change alone never counts as a latch change
    property p_hold; !(cyc_en_i && (file_wr_i || bit_op_i) && file_addr_i == 7'h06)
        |=> (second_port_pin_o & $past(second_port_pin_oe_o))
        == ($past(second_port_pin_o) & second_port_pin_oe_o); endproperty
    a_hold: assert property (p_hold) else $error("latch changed");
    property p_frz; !cyc_en_i |=> $stable(second_port_pin_oe_o); endproperty
    a_frz: assert property (p_frz) else $error("moved while frozen");
endmodule
bind bioprt_ports bioprt_checker u_chk (.*);
`default_nettype wire

/* File: bench/bioprt_pins_model.sv */
// outside circuitry on one port: a level source on every pin the block leaves floating
`timescale 1ns/100ps
`default_nettype none
module bioprt_pins_model #(parameter int W = 8) (
    input  wire logic [W-1:0] oe_i, out_i, ext_i,
    output wire logic [W-1:0] pin_o
);
    // no keeper: a floating pin shows only what the outside drives now
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

/* File: bench/tb_bioprt_ports.sv */
// self-checking bench for the port block
`timescale 1ns/100ps
`default_nettype none
module tb_bioprt_ports;
    logic ref_clk_i = 0, nrst_i = 0, cyc_en_i = 1, file_wr_i = 0, bit_op_i = 0, bit_val_i = 0;
    logic dir_wr_i = 0, file_hit_o;
    logic [6:0] file_addr_i = 7'h05;
    logic [7:0] file_wdata_i = 8'h00, work_reg_i = 8'hFF, ext2 = 8'h00, file_rdata_o;
    logic [2:0] bit_idx_i = 3'h0;
    logic [1:0] dir_sel_i = 2'h0;
    logic [3:0] first_port_pin_i = 4'h0, first_port_pin_o, first_port_pin_oe_o;
    logic [7:0] second_port_pin_i, second_port_pin_o, second_port_pin_oe_o;
    logic [7:0] third_port_pin_i, third_port_pin_o, third_port_pin_oe_o;
    int n_mismatch = 0, compares = 0, cyc = 0;
    logic [30:0] rows [4] = '{{7'h05, 8'hFF, 8'h39, 8'h09}, {7'h06, 8'hA5, 8'h3C, 8'hAC},
                              {7'h07, 8'h5A, 8'h00, 8'h5A}, {7'h06, 8'h0F, 8'hF0, 8'h00}};
    bioprt_ports dut (.*);
    bioprt_pins_model m2 (.oe_i(second_port_pin_oe_o), .out_i(second_port_pin_o),
                          .ext_i(ext2), .pin_o(second_port_pin_i));
    bioprt_pins_model m3 (.oe_i(third_port_pin_oe_o), .out_i(third_port_pin_o),
                          .ext_i(ext2), .pin_o(third_port_pin_i));
    always #2.5 ref_clk_i = ~ref_clk_i;
    task automatic cyc1; @(posedge ref_clk_i); #1; endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // k: 1 byte write, 2 direction load (select in a), 3 bit op (index d[2:0], value d[3])
    task automatic op(input int k, input logic [6:0] a, input logic [7:0] d);
        {file_addr_i, file_wdata_i, work_reg_i, dir_sel_i} = {a, d, d, a[1:0]};
        {bit_idx_i, bit_val_i} = {d[2:0], d[3]};
        {file_wr_i, dir_wr_i, bit_op_i} = {k == 1, k == 2, k == 3};
        cyc1;
        {file_wr_i, dir_wr_i, bit_op_i} = 3'h0;
    endtask
    always @(posedge ref_clk_i) if (++cyc > 200) begin n_mismatch++; end_of_test; end
    initial begin
        repeat (12) cyc1;
        chk(second_port_pin_oe_o, 8'h00);
        nrst_i = 1;
        // latches power up unknown, so give them values before any driver turns on
        op(1, 7'h06, 8'h00);
        op(1, 7'h07, 8'h00);
        op(2, 7'h02, 8'h0F);
        op(2, 7'h03, 8'h00);
        chk({4'h0, first_port_pin_oe_o}, 8'h00);
        foreach (rows[i]) begin
            op(1, rows[i][30:24], rows[i][23:16]);
            {ext2, first_port_pin_i} = {rows[i][15:8], rows[i][11:8]};
            #1 chk(file_rdata_o, rows[i][7:0]);
            cyc1;
        end
        chk({7'h00, file_hit_o}, 8'h01);
        chk(third_port_pin_o, 8'h5A);
        chk(third_port_pin_oe_o, 8'hFF);
        ext2 = 8'h35;
        op(3, 7'h06, 8'h0F);
        op(2, 7'h02, 8'h00);
        chk(second_port_pin_o, 8'h85);
        nrst_i = 0;
        cyc1;
        chk(second_port_pin_oe_o, 8'h00);
        nrst_i = 1;
        op(2, 7'h02, 8'h00);
        chk(second_port_pin_o, 8'h85);
        cyc_en_i = 0;
        op(1, 7'h06, 8'h11);
        cyc_en_i = 1;
        chk(second_port_pin_o, 8'h85);
        op(2, 7'h01, 8'h0A);
        chk({4'h0, first_port_pin_oe_o}, 8'h05);
        chk({4'h0, first_port_pin_o}, 8'h05);
        op(2, 7'h00, 8'hFF);
        chk(second_port_pin_oe_o, 8'hFF);
        chk({7'h00, file_hit_o}, 8'h00);
        end_of_test;
    end
endmodule
`default_nettype wire
